// >>> logic/dual_timer_regs.svh
// Purpose: Register indexes, bit positions and counts for the dual timer/counter.
// Assumes: Register index N sits at AXI byte address 4*N.
// Notes:   Operation list follows.
// Operation
// - Timer operation adds one per machine cycle, every twelve clocks.
// - Counter operation adds one per recognised falling edge, taking two machine cycles.
// - Mode register: upper nibble timer b, lower timer a; gate, select, mode.
// - Mode field: 0 13-bit, 1 16-bit, 2 8-bit reload, 3 split/hold.
// - Select bit 1 counts input falling edges; 0 counts machine cycles.
// - Timer advances while run bit set and gate off or gate input high.
// - 13-bit mode uses high byte and low five bits; rollover sets overflow.
// - Setting a run bit leaves count bytes unchanged.
// - 16-bit mode as 13-bit but with all sixteen bits.
// - Reload mode: low byte overflow sets flag, copies high byte into low.
// - Timer b in mode 3 holds its count as if stopped.
// - Timer a mode 3: low byte own counter; high byte uses b run/flag.
// - Timer a in mode 3: timer b still counts, no flag, run by mode.
// - Overflow flags set by hardware, cleared by software or interrupt service.
// - Control bit 6 runs timer b, bit 4 runs timer a.
// - Control bits 3..0: irq b edge, irq b type, irq a edge, irq a type.
// - Mode and control registers reset to zero.
// - Timer b overflow drives the serial baud source.
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH

`define IDX_CONTROL  8'h88
`define IDX_MODE     8'h89
`define IDX_CNT_LO_A 8'h8a
`define IDX_CNT_HI_A 8'h8b
`define IDX_CNT_LO_B 8'h8c
`define IDX_CNT_HI_B 8'h8d

`define CTRL_RESET   8'h00
`define MODE_RESET   8'h00

`define BIT_OVF_B    7
`define BIT_RUN_B    6
`define BIT_OVF_A    5
`define BIT_RUN_A    4
`define BIT_TYPE_B   2
`define BIT_TYPE_A   0

`define MC_LAST      4'hb
`define LOW13_MSB    4

`define AXI_AW       12
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// >>> logic/dual_timer_pkg.sv
// Purpose: Types shared by the dual timer/counter.
// Assumes: dual_timer_regs.svh supplies the widths.
// Notes:   Whole module state is one packed struct.
`default_nettype none
`include "dual_timer_regs.svh"
package dual_timer_pkg;
    typedef enum logic [1:0] {
        MODE_13B    = 2'h0,
        MODE_16B    = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT  = 2'h3
    } mode_t;

    typedef struct packed {
        logic  gate;
        logic  ct;
        mode_t mode;
    } tmode_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } cnt_t;

    typedef struct packed {
        logic ovf;
        cnt_t c;
    } step_t;

    typedef enum logic [2:0] {
        SEL_CTRL = 3'h0,
        SEL_MODE = 3'h1,
        SEL_LO_A = 3'h2,
        SEL_HI_A = 3'h3,
        SEL_LO_B = 3'h4,
        SEL_HI_B = 3'h5,
        SEL_NONE = 3'h7
    } sel_t;

    typedef struct packed {
        logic [3:0]         presc;
        logic [7:0]         ctrl;
        tmode_t             mb;
        tmode_t             ma;
        cnt_t               ca;
        cnt_t               cb;
        logic [3:0]         sync1;
        logic [3:0]         sync2;
        logic [1:0]         samp;
        logic               baud;
        logic               aw_hold;
        logic [`AXI_AW-1:0] aw_addr;
        logic               w_hold;
        logic [7:0]         w_data;
        logic               w_lane;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [7:0]         rdata;
        logic [1:0]         rresp;
    } state_t;
endpackage
`default_nettype wire

// >>> logic/dual_timer_counter.sv
// Purpose: Two 16-bit timer/counters with four modes behind an AXI4-Lite slave.
// Assumes: One clock; count and gate pins are asynchronous to it.
// Notes:   Answers one write and one read at a time; registers are 8 bits wide.
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_regs.svh"
module dual_timer_counter (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [`AXI_AW-1:0] awaddr,
    input  wire logic [2:0]         awprot,
    input  wire logic               wvalid,
    output logic                    wready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    output logic                    bvalid,
    input  wire logic               bready,
    output logic [1:0]              bresp,
    input  wire logic               arvalid,
    output logic                    arready,
    input  wire logic [`AXI_AW-1:0] araddr,
    input  wire logic [2:0]         arprot,
    output logic                    rvalid,
    input  wire logic               rready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    input  wire logic               count_input_a,
    input  wire logic               count_input_b,
    input  wire logic               gate_input_a,
    input  wire logic               gate_input_b,
    input  wire logic               irq_ack_a,
    input  wire logic               irq_ack_b,
    output logic                    ovf_flag_a,
    output logic                    ovf_flag_b,
    output logic                    ext_irq_type_a,
    output logic                    ext_irq_type_b,
    output logic                    baud_tick
);
    dual_timer_pkg::state_t s;
    dual_timer_pkg::state_t n;
    logic                   mc_tick;
    logic [1:0]             fall;
    logic                   split;
    logic                   run_a;
    logic                   run_b;
    logic                   ev_a;
    logic                   ev_b;
    logic                   ev_th;
    logic                   set_a;
    logic                   set_b;
    logic                   do_wr;
    dual_timer_pkg::sel_t   wsel;
    dual_timer_pkg::step_t  st_a;
    dual_timer_pkg::step_t  st_b;
    logic [8:0]             th_sum;

    function automatic dual_timer_pkg::sel_t reg_sel(input logic [`AXI_AW-1:0] addr);
        reg_sel = dual_timer_pkg::SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[`AXI_AW-1:10] == '0) begin
            unique case (addr[9:2])
                `IDX_CONTROL:  reg_sel = dual_timer_pkg::SEL_CTRL;
                `IDX_MODE:     reg_sel = dual_timer_pkg::SEL_MODE;
                `IDX_CNT_LO_A: reg_sel = dual_timer_pkg::SEL_LO_A;
                `IDX_CNT_HI_A: reg_sel = dual_timer_pkg::SEL_HI_A;
                `IDX_CNT_LO_B: reg_sel = dual_timer_pkg::SEL_LO_B;
                `IDX_CNT_HI_B: reg_sel = dual_timer_pkg::SEL_HI_B;
                default:       reg_sel = dual_timer_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // One counting step in the given mode; split mode steps the low byte only
    function automatic dual_timer_pkg::step_t step(input dual_timer_pkg::cnt_t c,
                                                   input dual_timer_pkg::mode_t m);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        s13 = {1'b0, c.hi, c.lo[`LOW13_MSB:0]} + 14'h1;
        s16 = {1'b0, c} + 17'h1;
        s8  = {1'b0, c.lo} + 9'h1;
        step = {1'b0, c};
        unique case (m)
            dual_timer_pkg::MODE_13B: begin
                // Upper three low-byte bits are left as they were
                step.ovf                   = s13[13];
                step.c.hi                  = s13[12:5];
                step.c.lo[`LOW13_MSB:0]    = s13[4:0];
            end
            dual_timer_pkg::MODE_16B: begin
                step.ovf = s16[16];
                step.c   = s16[15:0];
            end
            dual_timer_pkg::MODE_RELOAD: begin
                step.ovf  = s8[8];
                step.c.lo = s8[8] ? c.hi : s8[7:0];
            end
            dual_timer_pkg::MODE_SPLIT: begin
                step.ovf  = s8[8];
                step.c.lo = s8[7:0];
            end
        endcase
    endfunction

    assign awready        = !s.aw_hold && !s.bvalid;
    assign wready         = !s.w_hold && !s.bvalid;
    assign arready        = !s.rvalid;
    assign bvalid         = s.bvalid;
    assign bresp          = s.bresp;
    assign rvalid         = s.rvalid;
    assign rdata          = {24'h0, s.rdata};
    assign rresp          = s.rresp;
    assign ovf_flag_a     = s.ctrl[`BIT_OVF_A];
    assign ovf_flag_b     = s.ctrl[`BIT_OVF_B];
    assign ext_irq_type_a = s.ctrl[`BIT_TYPE_A];
    assign ext_irq_type_b = s.ctrl[`BIT_TYPE_B];
    assign baud_tick      = s.baud;

    always_comb begin
        n       = s;
        mc_tick = (s.presc == `MC_LAST);
        n.presc = mc_tick ? 4'h0 : s.presc + 4'h1;
        // Pins pass two flops; only the second is looked at
        n.sync1 = {gate_input_b, gate_input_a, count_input_b, count_input_a};
        n.sync2 = s.sync1;
        // High sample then low sample one machine cycle later
        fall    = mc_tick ? (s.samp & ~s.sync2[1:0]) : 2'h0;
        if (mc_tick) begin
            n.samp = s.sync2[1:0];
        end

        split = (s.ma.mode == dual_timer_pkg::MODE_SPLIT);
        run_a = s.ctrl[`BIT_RUN_A] && (!s.ma.gate || s.sync2[2]);
        ev_a  = run_a && (s.ma.ct ? fall[0] : mc_tick);
        // With a split, timer b ignores its run bit and stops only in its own mode 3 or when its gate holds it
        run_b = (split || s.ctrl[`BIT_RUN_B]) && (!s.mb.gate || s.sync2[3]) &&
                (s.mb.mode != dual_timer_pkg::MODE_SPLIT);
        ev_b  = run_b && (s.mb.ct ? fall[1] : mc_tick);
        ev_th = split && s.ctrl[`BIT_RUN_B] && mc_tick;

        st_a   = step(s.ca, s.ma.mode);
        st_b   = step(s.cb, s.mb.mode);
        th_sum = {1'b0, s.ca.hi} + 9'h1;
        if (ev_a) begin
            n.ca = st_a.c;
        end
        if (ev_th) begin
            n.ca.hi = th_sum[7:0];
        end
        if (ev_b) begin
            n.cb = st_b.c;
        end
        set_a  = ev_a && st_a.ovf;
        set_b  = split ? (ev_th && th_sum[8]) : (ev_b && st_b.ovf);
        n.baud = ev_b && st_b.ovf;

        if (irq_ack_a) begin
            n.ctrl[`BIT_OVF_A] = 1'b0;
        end
        if (irq_ack_b) begin
            n.ctrl[`BIT_OVF_B] = 1'b0;
        end

        if (awvalid && awready) begin
            n.aw_hold = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            n.w_hold = 1'b1;
            n.w_data = wdata[7:0];
            n.w_lane = wstrb[0];
        end
        do_wr = s.aw_hold && s.w_hold;
        wsel  = reg_sel(s.aw_addr);
        if (do_wr) begin
            n.aw_hold = 1'b0;
            n.w_hold  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = (wsel == dual_timer_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            // Written after the step so software wins the cycle
            if (s.w_lane) begin
                unique case (wsel)
                    dual_timer_pkg::SEL_CTRL: n.ctrl      = s.w_data;
                    dual_timer_pkg::SEL_MODE: {n.mb, n.ma} = s.w_data;
                    dual_timer_pkg::SEL_LO_A: n.ca.lo     = s.w_data;
                    dual_timer_pkg::SEL_HI_A: n.ca.hi     = s.w_data;
                    dual_timer_pkg::SEL_LO_B: n.cb.lo     = s.w_data;
                    dual_timer_pkg::SEL_HI_B: n.cb.hi     = s.w_data;
                    default: ;
                endcase
            end
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end

        // A flag set by hardware outlasts a clear in the same cycle
        if (set_a) begin
            n.ctrl[`BIT_OVF_A] = 1'b1;
        end
        if (set_b) begin
            n.ctrl[`BIT_OVF_B] = 1'b1;
        end

        if (arvalid && arready) begin
            n.rvalid = 1'b1;
            n.rresp  = `RESP_OKAY;
            unique case (reg_sel(araddr))
                dual_timer_pkg::SEL_CTRL: n.rdata = s.ctrl;
                dual_timer_pkg::SEL_MODE: n.rdata = {s.mb, s.ma};
                dual_timer_pkg::SEL_LO_A: n.rdata = s.ca.lo;
                dual_timer_pkg::SEL_HI_A: n.rdata = s.ca.hi;
                dual_timer_pkg::SEL_LO_B: n.rdata = s.cb.lo;
                dual_timer_pkg::SEL_HI_B: n.rdata = s.cb.hi;
                default: begin
                    n.rdata = 8'h0;
                    n.rresp = `RESP_SLVERR;
                end
            endcase
        end else if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s             <= '0;
            s.ctrl        <= `CTRL_RESET;
            {s.mb, s.ma}  <= `MODE_RESET;
        end else begin
            s <= n;
        end
    end

    tick_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mc_tick |-> ##12 mc_tick) else $error("machine cycle not twelve clocks");
    tick_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mc_tick |=> !mc_tick [*8]) else $error("machine cycle tick too early");
    stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!s.ctrl[`BIT_RUN_A] && !do_wr) |=> $stable(s.ca.lo))
        else $error("timer a low byte moved while stopped");
    reload_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev_a && s.ma.mode == dual_timer_pkg::MODE_RELOAD && s.ca.lo == 8'hff && !do_wr)
        |=> (s.ca.lo == $past(s.ca.hi)) && s.ctrl[`BIT_OVF_A])
        else $error("reload did not copy high byte");
    b_split_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.mb.mode == dual_timer_pkg::MODE_SPLIT && !do_wr) |=> $stable(s.cb))
        else $error("timer b moved in mode 3");
    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        set_b |=> s.ctrl[`BIT_OVF_B]) else $error("overflow flag b not set");
    edge_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.ma.ct && s.ma.mode == dual_timer_pkg::MODE_16B && run_a && fall[0] && !do_wr)
        |=> s.ca == $past(s.ca) + 16'h1) else $error("edge not counted");
    wr_priority_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_wr && s.w_lane && wsel == dual_timer_pkg::SEL_LO_B) |=> s.cb.lo == $past(s.w_data))
        else $error("count write lost to increment");
    reset_zero_a: assert property (@(posedge aclk)
        !aresetn |=> (s.ctrl == 8'h0 && {s.mb, s.ma} == 8'h0))
        else $error("control or mode not zero after reset");
    // Timer b keeps overflowing under a split, but only the high byte of timer a may raise its flag
    split_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (split && !ev_th && !(do_wr && wsel == dual_timer_pkg::SEL_CTRL)) |=> !$rose(ovf_flag_b))
        else $error("overflow flag b raised by timer b during split");
    ctrl_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_wr && s.w_lane && wsel == dual_timer_pkg::SEL_CTRL && !ev_a && !ev_th) |=> $stable(s.ca))
        else $error("control write changed timer a count");
    ack_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_ack_a && !set_a && !(do_wr && wsel == dual_timer_pkg::SEL_CTRL)) |=> !ovf_flag_a)
        else $error("service did not clear overflow flag a");
endmodule // dual_timer_counter
`default_nettype wire

// >>> verif/pin_source.sv
// Purpose: Far-side model of the count and gate pins.
// Assumes: Each level is held two machine cycles, so no edge is lost.
// Notes:   Count pins idle high; gate pins start low.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    input  wire logic aclk,
    output logic      cnt_a,
    output logic      cnt_b,
    output logic      gate_a,
    output logic      gate_b
);
    localparam int HOLD = 24;
    initial begin
        cnt_a = 1'b1;
        cnt_b = 1'b1;
        gate_a = 1'b0;
        gate_b = 1'b0;
    end
    task automatic gates(input logic g);
        @(posedge aclk);
        gate_a <= g;
        gate_b <= g;
    endtask
    // Levels longer than a machine cycle, so the sampler cannot miss one
    task automatic pulse(input int na, input int nb);
        for (int i = 0; i < na || i < nb; i++) begin
            @(posedge aclk);
            cnt_a <= (i >= na);
            cnt_b <= (i >= nb);
            repeat (HOLD) @(posedge aclk);
            cnt_a <= 1'b1;
            cnt_b <= 1'b1;
            repeat (HOLD) @(posedge aclk);
        end
    endtask
endmodule // pin_source
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the dual timer/counter over AXI4-Lite.
// Assumes: Window of 12*k clocks between run and stop gives exactly k ticks.
// Notes:   Flag and baud events are counted by a monitor, since stop clears flags.
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_regs.svh"
module testbench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack_a, ack_b;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic        awready, wready, bvalid, arready, rvalid, fa, fb, ta, tb, baud, ca, cb, ga, gb, pa, pb;
    int          cyc, miscompares, n_checks, n_fa, n_fb, n_bd, t0, t1, s, s2, s3;

    dual_timer_counter dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .count_input_a(ca), .count_input_b(cb), .gate_input_a(ga),
        .gate_input_b(gb), .irq_ack_a(ack_a), .irq_ack_b(ack_b), .ovf_flag_a(fa), .ovf_flag_b(fb),
        .ext_irq_type_a(ta), .ext_irq_type_b(tb), .baud_tick(baud));
    pin_source pins (.aclk(aclk), .cnt_a(ca), .cnt_b(cb), .gate_a(ga), .gate_b(gb));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic test_done();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard well above the roughly one thousand cycles the sequence needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        pa <= fa;
        pb <= fb;
        if (fa && !pa) n_fa <= n_fa + 1;
        if (fb && !pb) n_fb <= n_fb + 1;
        if (baud) n_bd <= n_bd + 1;
        if (cyc > 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic got;
        got = 1'b0;
        t0 = cyc;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                rsp = bresp;
                bready <= 1'b0;
                got = 1'b1;
            end
        end
        t1 = cyc;
    endtask

    task automatic rda(input logic [11:0] a);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rd = rdata;
                rsp = rresp;
                rready <= 1'b0;
                got = 1'b1;
            end
        end
    endtask

    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        rda(ad(i));
        chk(rd, {24'h0, e});
    endtask

    task automatic ld(input logic [7:0] m, la, ha, lb, hb);
        wr(ad(`IDX_MODE), m);
        wr(ad(`IDX_CNT_LO_A), la);
        wr(ad(`IDX_CNT_HI_A), ha);
        wr(ad(`IDX_CNT_LO_B), lb);
        wr(ad(`IDX_CNT_HI_B), hb);
    endtask

    // Hold register i at run for exactly 12*k clocks between the two updates
    task automatic tmr(input logic [7:0] i, input logic [7:0] run, input logic [7:0] stop, input int k);
        int c1, d;
        wr(ad(i), run);
        c1 = t1;
        d = t1 - t0;
        while (cyc < c1 + 12 * k - d) @(posedge aclk);
        wr(ad(i), stop);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ack_a, ack_b, pa, pb} = '0;
        {awaddr, araddr, wdata} = '0;
        s3 = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`IDX_CONTROL, 8'h00);
        rc(`IDX_MODE, 8'h00);
        rda(12'h300);
        chk(32'(rsp), 32'(`RESP_SLVERR));
        wr(12'h300, 8'h55);
        chk(32'(rsp), 32'(`RESP_SLVERR));
        wr(ad(`IDX_CONTROL), 8'h05);
        rc(`IDX_CONTROL, 8'h05);
        chk(32'({ta, tb}), 32'h3);
        ld(8'h01, 8'hfe, 8'hff, 8'h00, 8'h00);
        s = n_fa;
        tmr(`IDX_CONTROL, 8'h10, 8'h00, 3);
        rc(`IDX_CNT_LO_A, 8'h01);
        rc(`IDX_CNT_HI_A, 8'h00);
        chk(32'(n_fa - s), 32'h1);
        ld(8'h00, 8'hfe, 8'hff, 8'h00, 8'h00);
        s = n_fa;
        tmr(`IDX_CONTROL, 8'h10, 8'h00, 3);
        rc(`IDX_CNT_LO_A, 8'he1);
        rc(`IDX_CNT_HI_A, 8'h00);
        chk(32'(n_fa - s), 32'h1);
        // Both timers reload, so each shows the copy
        ld(8'h22, 8'hfe, 8'h80, 8'hfe, 8'h80);
        s = n_bd;
        s2 = n_fb;
        s3 = n_fa;
        tmr(`IDX_CONTROL, 8'h50, 8'h00, 3);
        rc(`IDX_CNT_LO_B, 8'h81);
        rc(`IDX_CNT_HI_B, 8'h80);
        rc(`IDX_CNT_LO_A, 8'h81);
        chk(32'(n_fa - s3), 32'h1);
        chk(32'(n_bd - s), 32'h1);
        chk(32'(n_fb - s2), 32'h1);
        ld(8'h30, 8'h00, 8'h00, 8'h44, 8'h12);
        tmr(`IDX_CONTROL, 8'h40, 8'h00, 3);
        rc(`IDX_CNT_LO_B, 8'h44);
        // Timer b parked in mode 3 while loading: under a split it runs whenever it leaves mode 3 and its gate allows
        ld(8'h33, 8'hfe, 8'h10, 8'h1e, 8'hff);
        s = n_fa;
        s2 = n_fb;
        s3 = n_bd;
        tmr(`IDX_CONTROL, 8'h50, 8'h00, 3);
        rc(`IDX_CNT_LO_A, 8'h01);
        rc(`IDX_CNT_HI_A, 8'h13);
        rc(`IDX_CNT_LO_B, 8'h1e);
        chk(32'(n_fa - s), 32'h1);
        tmr(`IDX_MODE, 8'h03, 8'h33, 3);
        rc(`IDX_CNT_LO_B, 8'h01);
        chk(32'(n_fb - s2), 32'h0);
        chk(32'(n_bd - s3), 32'h1);
        ld(8'hdd, 8'hfb, 8'hff, 8'hfd, 8'hff);
        pins.gates(1'b1);
        wr(ad(`IDX_CONTROL), 8'h50);
        pins.pulse(5, 3);
        repeat (40) @(posedge aclk);
        pins.gates(1'b0);
        pins.pulse(2, 2);
        repeat (40) @(posedge aclk);
        chk(32'(fa), 32'h1);
        chk(32'(fb), 32'h1);
        ack_a <= 1'b1;
        ack_b <= 1'b1;
        @(posedge aclk);
        ack_a <= 1'b0;
        ack_b <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(32'(fa), 32'h0);
        chk(32'(fb), 32'h0);
        rc(`IDX_CNT_LO_A, 8'h00);
        rc(`IDX_CNT_HI_A, 8'h00);
        rc(`IDX_CNT_LO_B, 8'h00);
        test_done();
    end
endmodule // testbench
`default_nettype wire
